// >>> verilog/flyback_defines.vh
`ifndef FLYBACK_DEFINES_VH
`define FLYBACK_DEFINES_VH
// Clock rate
`define CLK_MHZ 125
// Times in their own units
`define SHORT_BLANK_NS 235
`define SENSE_SHORT_US 10
`define EXT_FAULT_US 300
`define STARTUP_TIMEOUT_MS 69
`define SR_MIN_OFF_NS 300
`define UVLO_FILTER_US 10
`define OVERLOAD_MS 68
`define SYNC_MAX_KHZ 85
`define SYNC_MIN_KHZ 20
`define SR_TURNON_DLY_NS 40
`define SR_REARM_DLY_NS 100
// Cycle counts derived from the rate
`define SHORT_BLANK_CYC ((`SHORT_BLANK_NS * `CLK_MHZ + 999) / 1000)
`define SENSE_SHORT_CYC (`SENSE_SHORT_US * `CLK_MHZ)
`define EXT_FAULT_CYC (`EXT_FAULT_US * `CLK_MHZ)
`define STARTUP_TIMEOUT_CYC (`STARTUP_TIMEOUT_MS * 1000 * `CLK_MHZ)
`define SR_MIN_OFF_CYC ((`SR_MIN_OFF_NS * `CLK_MHZ + 999) / 1000)
`define UVLO_FILTER_CYC (`UVLO_FILTER_US * `CLK_MHZ)
`define OVERLOAD_CYC (`OVERLOAD_MS * 1000 * `CLK_MHZ)
`define SYNC_MIN_PERIOD_CYC ((`CLK_MHZ * 1000 + `SYNC_MAX_KHZ - 1) / `SYNC_MAX_KHZ)
`define SYNC_MAX_PERIOD_CYC ((`CLK_MHZ * 1000) / `SYNC_MIN_KHZ)
`define SR_TURNON_DLY_CYC ((`SR_TURNON_DLY_NS * `CLK_MHZ + 999) / 1000)
`define SR_REARM_DLY_CYC ((`SR_REARM_DLY_NS * `CLK_MHZ + 999) / 1000)
// Sync pulse high width
`define SYNC_PULSE_CYC 125
// Secondary sequencer states
`define SEC_IDLE 2'h0
`define SEC_CONFIG 2'h1
`define SEC_RUN 2'h2
`endif

// >>> verilog/sync_2ff.v
`timescale 1ns/1ps
module sync_2ff #(
    parameter W = 1
) (
    input wire clk,
    input wire rstn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_reg;

    // Two flops for inputs from outside the clock
    always @(posedge clk) begin
        if (!rstn) begin
            meta_reg <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// >>> verilog/flyback_fault_and_sr_sequencer.v
// Operation
// R1 - Short-circuit comparator trip raises fault, short blanking
// R2 - Supply overvoltage raises auto-restart fault
// R3 - Brown-out raises auto-restart fault
// R4 - Thermal stops switching, latched until clear
// R5 - No secondary start-up in timeout: fault
// R6 - Open sense pin raises short-circuit fault
// R7 - Long on-time with zero sense: fault
// R8 - Filtered external-fault low forces sync high
// R9 - External flag cleared only at restart level
// R10 - Self-configuration first after secondary turn-on
// R11 - Cable compensation only if capacitor; 20kHz floor
// R12 - Zero crossing while armed sets gate, delayed
// R13 - Raised threshold allows turn-off in min on-time
// R14 - DCM: disarm until min off and sync
// R15 - Sync edge turns gate off; rearm above 1.6V
// R16 - Burst disables driver, logic keeps running
// R17 - Sync frequency falls with comp, capped
// R18 - Comp above burst threshold enters burst
// R19 - Below turn-off level resets secondary state
// R20 - Undervoltage filtered before lockout
// R21 - Overload beyond delay forces sync low, sticky
// R22 - Overload timer also runs at bottom comp
// R23 - Auto-restart: stop, clear at restart level, recharge
// R24 - Inputs synchronised, delays counted in cycles; comp_level is used without a synchroniser
// R25 - Faults hold gate off; forced sync is fault
`timescale 1ns/1ps
`include "flyback_defines.vh"
module flyback_fault_and_sr_sequencer #(
    parameter STARTUP_CYC = `STARTUP_TIMEOUT_CYC,
    parameter OVERLOAD_CYC = `OVERLOAD_CYC,
    parameter EXT_CYC = `EXT_FAULT_CYC,
    parameter SENSE_SHORT_CYC = `SENSE_SHORT_CYC,
    parameter UVLO_CYC = `UVLO_FILTER_CYC,
    parameter COMP_W = 8,
    parameter [COMP_W-1:0] BURST_LEVEL = 8'he0,
    parameter [COMP_W-1:0] COMP_BOTTOM = 8'h08
) (
    input wire clk,
    input wire rstn,
    input wire short_circuit_cmp,
    input wire supply_ov,
    input wire brown_out,
    input wire thermal_hot,
    input wire cs_near_zero,
    input wire external_fault_pin_low,
    input wire below_auto_restart_level,
    input wire pwm_request,
    input wire sync_rx,
    input wire vdd_above_turnon,
    input wire vdd_below_turnoff,
    input wire cable_cap_present,
    input wire rectifier_drain_sense,
    input wire raised_turnoff_threshold,
    input wire drain_above_rearm,
    input wire overload_cmp,
    input wire [COMP_W-1:0] comp_level,
    output reg primary_gate,
    output reg charge_source_en,
    output wire short_circuit_fault,
    output wire supply_overvoltage_fault,
    output wire input_undervoltage_fault,
    output wire primary_thermal_fault,
    output wire startup_timeout_fault,
    output wire sense_short_fault,
    output wire ext_fault_flag,
    output reg sync_tx_force_high,
    output reg rectifier_gate,
    output reg sync_tx,
    output reg burst_mode,
    output reg cable_comp_en,
    output reg output_overload_fault,
    output reg secondary_undervoltage_lockout,
    output reg [1:0] sec_state
);
    localparam ST_IDLE = `SEC_IDLE;
    localparam ST_CONFIG = `SEC_CONFIG;
    localparam ST_RUN = `SEC_RUN;

    // R24 input synchronisers
    wire [17:0] raw_in = {short_circuit_cmp, supply_ov, brown_out, thermal_hot, cs_near_zero,
        external_fault_pin_low, below_auto_restart_level, sync_rx, vdd_above_turnon, vdd_below_turnoff,
        cable_cap_present, rectifier_drain_sense, raised_turnoff_threshold, drain_above_rearm,
        overload_cmp, pwm_request, 2'b00};
    wire [17:0] s;
    sync_2ff #(.W(18)) u_sync (.clk(clk), .rstn(rstn), .d(raw_in), .q(s));
    wire scp_s = s[17];
    wire ovp_s = s[16];
    wire bo_s = s[15];
    wire hot_s = s[14];
    wire csz_s = s[13];
    wire ext_s = s[12];
    wire aut_s = s[11];
    wire sync_s = s[10];
    wire on_s = s[9];
    wire off_s = s[8];
    wire cap_s = s[7];
    wire zc_s = s[6];
    wire roff_s = s[5];
    wire rearm_s = s[4];
    wire ol_s = s[3];
    wire req_s = s[2];

    // Saturating timer step
    function [31:0] tick;
        input cond;
        input [31:0] cnt;
        input [31:0] lim;
        begin
            tick = !cond ? 32'h0 : (cnt >= lim ? cnt : cnt + 32'h1);
        end
    endfunction

    // Primary fault flags
    reg [6:0] flag_reg;
    reg [31:0] ext_cnt_reg;
    reg [31:0] su_cnt_reg;
    reg [31:0] on_cnt_reg;
    reg started_reg;
    reg sync_d_reg;
    assign short_circuit_fault = flag_reg[0];
    assign supply_overvoltage_fault = flag_reg[1];
    assign input_undervoltage_fault = flag_reg[2];
    assign primary_thermal_fault = flag_reg[3];
    assign startup_timeout_fault = flag_reg[4];
    assign sense_short_fault = flag_reg[5];
    assign ext_fault_flag = flag_reg[6];
    wire any_fault = |flag_reg;
    wire blank_done = on_cnt_reg >= `SHORT_BLANK_CYC;
    wire sync_rise = sync_s & ~sync_d_reg;
    wire [6:0] set_vec;
    // R1 R6 blanked short-circuit trip, open pin reads high
    assign set_vec[0] = primary_gate & blank_done & scp_s;
    // R2 overvoltage
    assign set_vec[1] = ovp_s;
    // R3 brown-out
    assign set_vec[2] = bo_s;
    // R4 thermal trip
    assign set_vec[3] = hot_s;
    // R5 start-up timeout
    assign set_vec[4] = su_cnt_reg >= STARTUP_CYC;
    // R7 long on-time with zero sense
    assign set_vec[5] = primary_gate & (on_cnt_reg >= SENSE_SHORT_CYC) & csz_s;
    // R8 filtered external pin
    assign set_vec[6] = ext_cnt_reg >= EXT_CYC;

    // Primary sequencing
    always @(posedge clk) begin
        if (!rstn) begin
            flag_reg <= 7'h00;
            ext_cnt_reg <= 32'h0;
            su_cnt_reg <= 32'h0;
            on_cnt_reg <= 32'h0;
            started_reg <= 1'b0;
            sync_d_reg <= 1'b0;
            primary_gate <= 1'b0;
            charge_source_en <= 1'b0;
            sync_tx_force_high <= 1'b0;
        end else begin
            sync_d_reg <= sync_s;
            ext_cnt_reg <= tick(ext_s, ext_cnt_reg, EXT_CYC);
            on_cnt_reg <= primary_gate ? on_cnt_reg + 32'h1 : 32'h0;
            if (sync_rise)
                started_reg <= 1'b1;
            su_cnt_reg <= (started_reg | any_fault) ? 32'h0 : su_cnt_reg + 32'h1;
            // R23 R9 R4 clear at restart level, set wins, thermal waits
            if (aut_s) begin
                flag_reg <= set_vec | (flag_reg & {1'b0, 2'b00, hot_s, 3'b000});
                started_reg <= 1'b0;
            end else begin
                flag_reg <= flag_reg | set_vec;
            end
            // R23 recharge source at restart level
            charge_source_en <= aut_s;
            // R8 sync forced high by external fault
            sync_tx_force_high <= flag_reg[6];
            // R25 R23 gate held off during faults
            if (any_fault | (|set_vec))
                primary_gate <= 1'b0;
            else
                primary_gate <= req_s;
        end
    end

    // Secondary sequencer
    reg [31:0] uv_cnt_reg;
    reg [31:0] ol_cnt_reg;
    reg [31:0] per_cnt_reg;
    reg [31:0] sr_cnt_reg;
    reg armed_reg;
    reg on_pend_reg;
    reg sync_int_d_reg;
    reg rearm_pend_reg;
    wire run = sec_state == ST_RUN;
    // R17 period grows with comp, never below max-frequency period
    wire [31:0] period = `SYNC_MIN_PERIOD_CYC + {24'h0, comp_level} * 32'd32;
    wire sync_edge = run & (per_cnt_reg == 32'h0);

    always @(posedge clk) begin
        if (!rstn) begin
            sec_state <= ST_IDLE;
            uv_cnt_reg <= 32'h0;
            secondary_undervoltage_lockout <= 1'b0;
        end else begin
            // R20 filter before lockout
            uv_cnt_reg <= tick(off_s, uv_cnt_reg, UVLO_CYC);
            secondary_undervoltage_lockout <= uv_cnt_reg >= UVLO_CYC;
            case (sec_state)
                // R10 configure before anything else
                ST_IDLE: if (on_s) sec_state <= ST_CONFIG;
                ST_CONFIG: sec_state <= ST_RUN;
                ST_RUN: if (secondary_undervoltage_lockout) sec_state <= ST_IDLE;
                default: sec_state <= ST_IDLE;
            endcase
        end
    end

    // Secondary datapath, reset whenever idle
    always @(posedge clk) begin
        // R19 idle resets all secondary datapath state
        if (!rstn || sec_state == ST_IDLE) begin
            cable_comp_en <= 1'b0;
            burst_mode <= 1'b0;
            per_cnt_reg <= 32'h0;
            sync_tx <= 1'b0;
            ol_cnt_reg <= 32'h0;
            output_overload_fault <= 1'b0;
            sr_cnt_reg <= 32'h0;
            armed_reg <= 1'b0;
            on_pend_reg <= 1'b0;
            rectifier_gate <= 1'b0;
            sync_int_d_reg <= 1'b0;
            rearm_pend_reg <= 1'b0;
        end else begin
            // R11 compensation from capacitor detect
            if (sec_state == ST_CONFIG) begin
                cable_comp_en <= cap_s;
                armed_reg <= 1'b1;
            end
            // R18 burst above threshold
            burst_mode <= comp_level > BURST_LEVEL;
            // R17 sync period counter, clamped to 20kHz floor
            if (run)
                per_cnt_reg <= (per_cnt_reg + 32'h1 >= period || per_cnt_reg + 32'h1 >= `SYNC_MAX_PERIOD_CYC)
                    ? 32'h0 : per_cnt_reg + 32'h1;
            sync_int_d_reg <= sync_edge;
            // R22 R21 overload timer, sticky flag
            ol_cnt_reg <= tick(ol_s | (comp_level < COMP_BOTTOM), ol_cnt_reg, OVERLOAD_CYC);
            if (ol_cnt_reg >= OVERLOAD_CYC)
                output_overload_fault <= 1'b1;
            // R21 sync held low in overload
            sync_tx <= run & ~output_overload_fault & ~burst_mode & (per_cnt_reg < `SYNC_PULSE_CYC);
            sr_cnt_reg <= rectifier_gate ? 32'h0 : sr_cnt_reg + 32'h1;
            if (sync_edge) begin
                // R15 R14 sync edge turns off, starts rearm delay only if gate was already off
                rectifier_gate <= 1'b0;
                on_pend_reg <= 1'b0;
                armed_reg <= 1'b0;
                rearm_pend_reg <= ~rectifier_gate;
                sr_cnt_reg <= 32'h0;
            end else if (rectifier_gate) begin
                // R13 raised threshold active through min on-time
                if (roff_s) begin
                    rectifier_gate <= 1'b0;
                    armed_reg <= 1'b0;
                end
            end else if (on_pend_reg) begin
                // R12 R16 turn-on delay, driver off in burst
                if (sr_cnt_reg >= `SR_TURNON_DLY_CYC) begin
                    on_pend_reg <= 1'b0;
                    rectifier_gate <= ~burst_mode;
                end
            end else if (armed_reg & zc_s) begin
                // R12 zero crossing sets driver
                on_pend_reg <= 1'b1;
                armed_reg <= 1'b0;
                sr_cnt_reg <= 32'h0;
            end else if (!armed_reg && sr_cnt_reg >= `SR_MIN_OFF_CYC) begin
                // R14 R15 rearm after min off and sync or drain level
                if ((rearm_pend_reg && sr_cnt_reg >= `SR_REARM_DLY_CYC) || (!rearm_pend_reg && rearm_s)) begin
                    armed_reg <= 1'b1;
                    rearm_pend_reg <= 1'b0;
                end
            end
        end
    end
endmodule

// >>> bench/sync_peer_model.sv
`timescale 1ns/1ps
module sync_peer_model (
    input wire clk,
    input wire run,
    output reg sync_rx = 1'b0
);
    reg [4:0] cnt_reg = 5'h0;
    // start-up pulses, never a stuck level
    always @(negedge clk) begin
        cnt_reg <= run ? cnt_reg + 5'h1 : 5'h0;
        sync_rx <= run && (cnt_reg < 5'h2);
    end
endmodule

// >>> bench/flyback_fault_and_sr_sequencer_properties.sv
`timescale 1ns/1ps
`include "flyback_defines.vh"
module flyback_fault_and_sr_sequencer_properties #(
    parameter [7:0] COMP_BOTTOM = 8'h08
) (
    input wire clk,
    input wire rstn,
    input wire thermal_hot,
    input wire external_fault_pin_low,
    input wire below_auto_restart_level,
    input wire overload_cmp,
    input wire [7:0] comp_level,
    input wire primary_gate,
    input wire charge_source_en,
    input wire short_circuit_fault,
    input wire supply_overvoltage_fault,
    input wire input_undervoltage_fault,
    input wire primary_thermal_fault,
    input wire startup_timeout_fault,
    input wire sense_short_fault,
    input wire ext_fault_flag,
    input wire sync_tx_force_high,
    input wire rectifier_gate,
    input wire sync_tx,
    input wire burst_mode,
    input wire output_overload_fault,
    input wire [1:0] sec_state
);
    // Any primary fault
    wire any_f = short_circuit_fault | supply_overvoltage_fault | input_undervoltage_fault
        | primary_thermal_fault | startup_timeout_fault | sense_short_fault | ext_fault_flag;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Flag held while its clear is absent
    sequence s_ext_held; (ext_fault_flag && !below_auto_restart_level) [*4]; endsequence
    sequence s_hot_held; (primary_thermal_fault && thermal_hot) [*4]; endsequence
    property p_gate_off; any_f |=> !primary_gate; endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate on during fault");
    property p_force; 1'b1 |=> sync_tx_force_high == $past(ext_fault_flag); endproperty
    a_force: assert property (p_force) else $error("sync force mismatch");
    property p_ext_rise;
        $rose(ext_fault_flag) |-> $past(external_fault_pin_low, 4) && $past(external_fault_pin_low, 8);
    endproperty
    a_ext_rise: assert property (p_ext_rise) else $error("external flag too early");
    property p_ext_hold; s_ext_held |=> ext_fault_flag; endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("external flag lost");
    property p_hot_hold; s_hot_held |=> primary_thermal_fault; endproperty
    a_hot_hold: assert property (p_hot_hold) else $error("thermal flag lost");
    property p_charge; below_auto_restart_level [*4] |-> charge_source_en; endproperty
    a_charge: assert property (p_charge) else $error("charge source off");
    property p_ov_rise;
        $rose(output_overload_fault) |-> $past(overload_cmp, 6) || ($past(comp_level, 6) <= COMP_BOTTOM);
    endproperty
    a_ov_rise: assert property (p_ov_rise) else $error("overload without cause");
    property p_ov_sync; output_overload_fault |=> !sync_tx; endproperty
    a_ov_sync: assert property (p_ov_sync) else $error("sync high in overload");
    property p_burst; burst_mode |=> !rectifier_gate; endproperty
    a_burst: assert property (p_burst) else $error("rectifier on in burst");
    property p_config; sec_state == `SEC_RUN |-> $past(sec_state) != `SEC_IDLE; endproperty
    a_config: assert property (p_config) else $error("run without config");
    property p_idle;
        sec_state == `SEC_IDLE && $past(sec_state) == `SEC_IDLE |-> !rectifier_gate && !sync_tx && !burst_mode;
    endproperty
    a_idle: assert property (p_idle) else $error("activity while idle");
endmodule

// >>> bench/flyback_fault_and_sr_sequencer_tb.sv
`timescale 1ns/1ps
`include "flyback_defines.vh"
module flyback_fault_and_sr_sequencer_tb;
    reg clk = 0, rstn = 0, run = 0, pwm_request = 0, external_fault_pin_low = 0;
    reg below_auto_restart_level = 0, vdd_above_turnon = 0, vdd_below_turnoff = 0;
    reg cable_cap_present = 0, rectifier_drain_sense = 0, raised_turnoff_threshold = 0;
    reg drain_above_rearm = 0, overload_cmp = 0;
    reg [4:0] f = 5'h00;
    reg [7:0] comp_level = 8'h40, lf = 8'h5b;
    wire sync_rx, primary_gate, charge_source_en, short_circuit_fault, supply_overvoltage_fault;
    wire input_undervoltage_fault, primary_thermal_fault, startup_timeout_fault, sense_short_fault;
    wire ext_fault_flag, sync_tx_force_high, rectifier_gate, sync_tx, burst_mode, cable_comp_en;
    wire output_overload_fault, secondary_undervoltage_lockout;
    wire [1:0] sec_state;
    wire [4:0] fl = {short_circuit_fault, supply_overvoltage_fault, input_undervoltage_fault,
        primary_thermal_fault, sense_short_fault};
    integer num_errors = 0, checks_done = 0, i, n, k, e;
    reg last;
    flyback_fault_and_sr_sequencer #(.STARTUP_CYC(60), .OVERLOAD_CYC(50), .EXT_CYC(50),
        .SENSE_SHORT_CYC(40), .UVLO_CYC(20)) i_dut (.*, .short_circuit_cmp(f[4]),
        .supply_ov(f[3]), .brown_out(f[2]), .thermal_hot(f[1]), .cs_near_zero(f[0]));
    sync_peer_model i_peer (.clk(clk), .run(run), .sync_rx(sync_rx));
    always #4 clk = ~clk;
    function [7:0] lfsr;
        input integer unused;
        begin
            lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
            lfsr = lf;
        end
    endfunction
    task cyc(input integer c); repeat (c) @(negedge clk); endtask
    task chk(input string s, input [15:0] x, input [15:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== x) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED %s expected %h seen %h", s, x, g);
            end
        end
    endtask
    task restart;
        begin
            below_auto_restart_level = 1;
            cyc(6);
            chk("charge", 1, charge_source_en);
            below_auto_restart_level = 0;
            cyc(6);
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d errors %0d", checks_done, num_errors);
            if (num_errors == 0 && checks_done > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // Watchdog
    initial begin
        #(8 * 95000);
        num_errors = num_errors + 1;
        wrap_up;
    end
    // Main sequence
    initial begin
        cyc(20);
        rstn = 1;
        chk("reset", 0, {fl, ext_fault_flag, sec_state});
        cyc(80);
        chk("startup", 1, startup_timeout_fault);
        run = 1;
        restart;
        chk("startup_clr", 0, startup_timeout_fault);
        pwm_request = 1;
        for (i = 0; i < 5; i = i + 1) begin
            cyc(60);
            f = 5'h10 >> i;
            cyc(60);
            chk("flags", 5'h10 >> i, fl);
            chk("gate", 0, primary_gate);
            if (i == 3) begin
                restart;
                chk("hot_held", 5'h02, fl);
            end
            f = 5'h00;
            restart;
            chk("cleared", 0, fl);
        end
        $display("test primary faults done");
        external_fault_pin_low = 1;
        cyc(10 + lfsr(0) % 30);
        external_fault_pin_low = 0;
        cyc(60);
        chk("ext_dip", 0, ext_fault_flag);
        external_fault_pin_low = 1;
        cyc(70);
        external_fault_pin_low = 0;
        cyc(20);
        chk("ext", 1, ext_fault_flag);
        chk("force", 1, sync_tx_force_high);
        restart;
        chk("ext_clr", 0, ext_fault_flag);
        $display("test external fault done");
        cable_cap_present = 1;
        vdd_above_turnon = 1;
        cyc(10);
        chk("state", `SEC_RUN, sec_state);
        chk("cable", 1, cable_comp_en);
        vdd_below_turnoff = 1;
        cyc(8);
        vdd_below_turnoff = 0;
        cyc(10);
        chk("uvlo_dip", `SEC_RUN, sec_state);
        for (i = 0; i < 2; i = i + 1) begin
            comp_level = (i == 0) ? 8'hd0 : 8'h10 + lfsr(0) % 8'h60;
            e = `SYNC_MIN_PERIOD_CYC + 32 * comp_level;
            if (e > `SYNC_MAX_PERIOD_CYC)
                e = `SYNC_MAX_PERIOD_CYC;
            n = 0;
            k = 0;
            last = 1;
            while (k < 3) begin
                @(negedge clk);
                n = (k < 2) ? 0 : n + 1;
                if (sync_tx && !last)
                    k = k + 1;
                last = sync_tx;
            end
            chk("period", e, n);
        end
        $display("test sync period done");
        cyc(30);
        rectifier_drain_sense = 1;
        cyc(20);
        chk("sr_on", 1, rectifier_gate);
        raised_turnoff_threshold = 1;
        cyc(6);
        chk("sr_off", 0, rectifier_gate);
        raised_turnoff_threshold = 0;
        drain_above_rearm = 1;
        cyc(60);
        chk("sr_rearm", 1, rectifier_gate);
        raised_turnoff_threshold = 1;
        drain_above_rearm = 0;
        cyc(6);
        chk("sr_off2", 0, rectifier_gate);
        rectifier_drain_sense = 0;
        raised_turnoff_threshold = 0;
        comp_level = 8'hf0;
        cyc(6300);
        chk("burst", 1, burst_mode);
        comp_level = 8'h40;
        cyc(6300);
        chk("burst_exit", 0, burst_mode);
        $display("test rectifier done");
        overload_cmp = 1;
        cyc(70);
        overload_cmp = 0;
        cyc(20);
        chk("olp", 1, output_overload_fault);
        vdd_above_turnon = 0;
        vdd_below_turnoff = 1;
        cyc(40);
        chk("lockout", 1, secondary_undervoltage_lockout);
        chk("idle", `SEC_IDLE, sec_state);
        chk("olp_clr", 0, output_overload_fault);
        vdd_below_turnoff = 0;
        vdd_above_turnon = 1;
        comp_level = 8'h00;
        cyc(80);
        chk("olp_comp", 1, output_overload_fault);
        $display("test secondary protection done");
        wrap_up;
    end
endmodule
bind flyback_fault_and_sr_sequencer flyback_fault_and_sr_sequencer_properties #(.COMP_BOTTOM(8'h08)) i_props (.*);
